// >>> rtl/scwd_pkg.sv
// constants for the synthesizer control word decode block
package scwd_pkg;
  localparam int         WORD_W          = 24;
  localparam int         ADDR_W          = 4;
  localparam int         FRAC_W          = 22;
  localparam int         BASE_W          = 12;
  localparam int         EXT_W           = 10;
  localparam logic [3:0] ADDR_CONTROL    = 4'hB;
  localparam logic [3:0] ADDR_FRAC_EXT   = 4'hD;
  localparam int         MAIN_DIV_BIT    = 0;
  localparam int         SEL_LSB         = 4;
  localparam int         REFMODE_BIT     = 8;
  localparam int         DOUBLER_BIT     = 9;
  localparam int         AUTO_PU_LSB     = 10;
  localparam int         ORDER_LSB       = 12;
  localparam int         FWIDTH_BIT      = 14;
  localparam int         AUX_POL_BIT     = 15;
  localparam int         AUX_HIZ_BIT     = 16;
  localparam int         MAIN_POL_BIT    = 17;
  localparam int         MAIN_HIZ_BIT    = 18;
  localparam int         NUM_EXT_LSB     = 4;
  localparam int         DEN_EXT_LSB     = 14;
  localparam logic [23:0] CONTROL_RESET  = 24'h000000;
  localparam logic [23:0] FRAC_EXT_RESET = 24'h000000;
  localparam logic [1:0] AUTO_PU_OFF     = 2'h0;
  localparam logic [1:0] AUTO_PU_MAIN    = 2'h1;
  localparam logic [1:0] AUTO_PU_BOTH    = 2'h2;
  typedef enum logic [1:0] {
    SCWD_ORDER_4TH    = 2'b00,
    SCWD_ORDER_BYPASS = 2'b01,
    SCWD_ORDER_2ND    = 2'b10,
    SCWD_ORDER_3RD    = 2'b11
  } scwd_order_e;
endpackage

// >>> rtl/scwd_shifter.sv
// serial word shifter with load enable latch strobe
`timescale 1ns/1ns
`default_nettype none
module scwd_shifter (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        serial_clock,
  input  wire logic                        serial_data,
  input  wire logic                        load_enable,
  output logic [scwd_pkg::WORD_W-1:0]      word,
  output logic                             word_valid
);
  logic [scwd_pkg::WORD_W-1:0] shift;
  logic [scwd_pkg::WORD_W-1:0] next_shift;
  logic                        sclk_prev;
  logic                        le_prev;
  logic [scwd_pkg::WORD_W-1:0] next_word;
  logic                        next_word_valid;

  always_comb begin
    next_shift      = shift;
    next_word       = word;
    next_word_valid = 1'b0;
    if (serial_clock && !sclk_prev) begin
      next_shift = {shift[scwd_pkg::WORD_W-2:0], serial_data};
    end
    if (load_enable && !le_prev) begin
      next_word       = shift; // RULE14
      next_word_valid = 1'b1;  // RULE14
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      shift      <= '0;
      sclk_prev  <= 1'b0;
      le_prev    <= 1'b0;
      word       <= '0;
      word_valid <= 1'b0;
    end else begin
      shift      <= next_shift;
      sclk_prev  <= serial_clock;
      le_prev    <= load_enable;
      word       <= next_word;
      word_valid <= next_word_valid;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/scwd_decode.sv
// control word and fraction extension decode
//
// Contract
// RULE1: select codes 0-2: hiz, high, low
// RULE2: codes 3-11 choose digital/analog lock detects
// RULE3: codes 12-15 output dividers halved
// RULE4: reference mode picks single-ended or differential
// RULE5: doubler bit zero bypasses the doubler
// RULE6: auto power-up on main divider write
// RULE7: modulator order field selects order or bypass
// RULE8: width bit picks 12 or 22 bits
// RULE9: aux pump polarity, one means positive
// RULE10: hiz bit, overridden by active auto power-up
// RULE11: main pump polarity, one means positive
// RULE12: numerator extension used only in 22-bit mode
// RULE13: denominator extension used only in 22-bit mode
// RULE14: 24-bit word, low nibble addresses, load latches
`timescale 1ns/1ns
`default_nettype none
module scwd_decode (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         serial_clock,
  input  wire logic                         serial_data,
  input  wire logic                         load_enable,
  input  wire logic                         main_digital_lock,
  input  wire logic                         aux_digital_lock,
  input  wire logic                         main_analog_lock,
  input  wire logic                         aux_analog_lock,
  input  wire logic [3:0]                   divider_outputs,
  input  wire logic [scwd_pkg::BASE_W-1:0]  numerator_low_bits,
  input  wire logic [scwd_pkg::BASE_W-1:0]  denominator_low_bits,
  output logic                              test_lock_pin_out,
  output logic                              test_lock_pin_oe_n,
  output logic                              reference_differential,
  output logic                              reference_doubler_enable,
  output logic                              main_power_up,
  output logic                              aux_power_up,
  output logic [1:0]                        modulator_order,
  output logic                              modulator_bypass,
  output logic                              fraction_width_select,
  output logic                              aux_pump_polarity,
  output logic                              aux_pump_hiz,
  output logic                              main_pump_polarity,
  output logic                              main_pump_hiz,
  output logic [scwd_pkg::FRAC_W-1:0]       fraction_numerator,
  output logic [scwd_pkg::FRAC_W-1:0]       fraction_denominator
);
  logic [scwd_pkg::WORD_W-1:0] word;
  logic                        word_valid;
  logic [scwd_pkg::WORD_W-1:0] control_word;
  logic [scwd_pkg::WORD_W-1:0] fraction_extension;
  logic [scwd_pkg::WORD_W-1:0] next_control_word;
  logic [scwd_pkg::WORD_W-1:0] next_fraction_extension;
  logic [3:0]                  div_prev;
  logic [3:0]                  div_half;
  logic [3:0]                  next_div_half;
  logic [3:0]                  pin_output_select;
  logic [1:0]                  auto_power_up;
  logic                        wide_fraction;
  logic                        main_pu_armed;
  logic                        aux_pu_armed;
  logic                        main_divider_write;
  logic                        next_pin_out;
  logic                        next_pin_oe_n;
  logic                        next_main_pu;
  logic                        next_aux_pu;
  logic                        next_main_hiz;
  logic                        next_aux_hiz;
  logic [scwd_pkg::FRAC_W-1:0] next_num;
  logic [scwd_pkg::FRAC_W-1:0] next_den;

  scwd_shifter u_shifter (
    .clock        (clock),
    .rst          (rst),
    .serial_clock (serial_clock),
    .serial_data  (serial_data),
    .load_enable  (load_enable),
    .word         (word),
    .word_valid   (word_valid)
  );

  // register write decode
  // words for other addresses leave both registers alone
  always_comb begin
    next_control_word       = control_word;
    next_fraction_extension = fraction_extension;
    if (word_valid && word[3:0] == scwd_pkg::ADDR_CONTROL) begin
      next_control_word = word; // RULE14
    end
    if (word_valid && word[3:0] == scwd_pkg::ADDR_FRAC_EXT) begin
      next_fraction_extension = word; // RULE14
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      control_word       <= scwd_pkg::CONTROL_RESET;
      fraction_extension <= scwd_pkg::FRAC_EXT_RESET;
    end else begin
      control_word       <= next_control_word;
      fraction_extension <= next_fraction_extension;
    end
  end

  assign pin_output_select  = control_word[scwd_pkg::SEL_LSB +: 4];
  assign auto_power_up      = control_word[scwd_pkg::AUTO_PU_LSB +: 2];
  assign wide_fraction      = control_word[scwd_pkg::FWIDTH_BIT];

  // auto power-up codes that arm each loop; the reserved code arms none
  assign main_pu_armed      = (auto_power_up == scwd_pkg::AUTO_PU_MAIN) ||
                              (auto_power_up == scwd_pkg::AUTO_PU_BOTH); // RULE6
  assign aux_pu_armed       = auto_power_up == scwd_pkg::AUTO_PU_BOTH; // RULE6
  // any latched word with a clear low bit is a main divider write
  assign main_divider_write = word_valid && !word[scwd_pkg::MAIN_DIV_BIT]; // RULE6

  // divide each divider output by two on its rising edge
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_half
      always_comb begin
        next_div_half[g] = div_half[g] ^ (divider_outputs[g] & ~div_prev[g]); // RULE3
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      div_prev <= 4'h0;
      div_half <= 4'h0;
    end else begin
      div_prev <= divider_outputs;
      div_half <= next_div_half;
    end
  end

  // test/lock pin selection; oe_n low while driving
  // open drain codes pull low without lock and release with lock
  always_comb begin
    next_pin_out  = 1'b0;
    next_pin_oe_n = 1'b0;
    case (pin_output_select)
      4'h0: next_pin_oe_n = 1'b1; // RULE1
      4'h1: next_pin_out  = 1'b1; // RULE1
      4'h2: next_pin_out  = 1'b0; // RULE1
      4'h3: next_pin_out  = main_digital_lock & aux_digital_lock; // RULE2
      4'h4: next_pin_out  = main_digital_lock; // RULE2
      4'h5: next_pin_out  = aux_digital_lock; // RULE2
      4'h6: next_pin_oe_n = main_analog_lock & aux_analog_lock; // RULE2
      4'h7: next_pin_oe_n = main_analog_lock; // RULE2
      4'h8: next_pin_oe_n = aux_analog_lock; // RULE2
      4'h9: next_pin_out  = main_analog_lock & aux_analog_lock; // RULE2
      4'hA: next_pin_out  = main_analog_lock; // RULE2
      4'hB: next_pin_out  = aux_analog_lock; // RULE2
      4'hC: next_pin_out  = div_half[0]; // RULE3
      4'hD: next_pin_out  = div_half[1]; // RULE3
      4'hE: next_pin_out  = div_half[2]; // RULE3
      4'hF: next_pin_out  = div_half[3]; // RULE3
      default: next_pin_oe_n = 1'b1;
    endcase
  end

  // power-up pulses, pump high impedance and fraction assembly
  always_comb begin
    next_main_pu = 1'b0;
    next_aux_pu  = 1'b0;
    if (main_divider_write) begin
      next_main_pu = main_pu_armed; // RULE6
      next_aux_pu  = aux_pu_armed; // RULE6
    end
    // an armed auto power-up overrides the pump high impedance bit
    next_main_hiz = control_word[scwd_pkg::MAIN_HIZ_BIT] & ~main_pu_armed; // RULE10
    next_aux_hiz  = control_word[scwd_pkg::AUX_HIZ_BIT] & ~aux_pu_armed; // RULE10
    if (wide_fraction) begin
      next_num = {fraction_extension[scwd_pkg::NUM_EXT_LSB +: scwd_pkg::EXT_W],
                  numerator_low_bits}; // RULE12
      next_den = {fraction_extension[scwd_pkg::DEN_EXT_LSB +: scwd_pkg::EXT_W],
                  denominator_low_bits}; // RULE13
    end else begin
      next_num = {{scwd_pkg::EXT_W{1'b0}}, numerator_low_bits}; // RULE12
      next_den = {{scwd_pkg::EXT_W{1'b0}}, denominator_low_bits}; // RULE13
    end
  end

  // every output is registered here
  always_ff @(posedge clock) begin
    if (rst) begin
      test_lock_pin_out        <= 1'b0;
      test_lock_pin_oe_n       <= 1'b1;
      reference_differential   <= 1'b0;
      reference_doubler_enable <= 1'b0;
      main_power_up            <= 1'b0;
      aux_power_up             <= 1'b0;
      modulator_order          <= 2'h0;
      modulator_bypass         <= 1'b0;
      fraction_width_select    <= 1'b0;
      aux_pump_polarity        <= 1'b0;
      aux_pump_hiz             <= 1'b0;
      main_pump_polarity       <= 1'b0;
      main_pump_hiz            <= 1'b0;
      fraction_numerator       <= '0;
      fraction_denominator     <= '0;
    end else begin
      test_lock_pin_out        <= next_pin_out;
      test_lock_pin_oe_n       <= next_pin_oe_n;
      reference_differential   <= control_word[scwd_pkg::REFMODE_BIT]; // RULE4
      reference_doubler_enable <= control_word[scwd_pkg::DOUBLER_BIT]; // RULE5
      main_power_up            <= next_main_pu;
      aux_power_up             <= next_aux_pu;
      modulator_order          <= control_word[scwd_pkg::ORDER_LSB +: 2]; // RULE7
      modulator_bypass         <= control_word[scwd_pkg::ORDER_LSB +: 2] ==
                                  scwd_pkg::SCWD_ORDER_BYPASS; // RULE7
      fraction_width_select    <= wide_fraction; // RULE8
      aux_pump_polarity        <= control_word[scwd_pkg::AUX_POL_BIT]; // RULE9
      aux_pump_hiz             <= next_aux_hiz;
      main_pump_polarity       <= control_word[scwd_pkg::MAIN_POL_BIT]; // RULE11
      main_pump_hiz            <= next_main_hiz;
      fraction_numerator       <= next_num;
      fraction_denominator     <= next_den;
    end
  end
endmodule
`default_nettype wire

// >>> sim/scwd_checker.sv
// port assertions for the control word decode block
`timescale 1ns/1ns
`default_nettype none
module scwd_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        load_enable,
  input wire logic        main_power_up,
  input wire logic        aux_power_up,
  input wire logic [1:0]  modulator_order,
  input wire logic        modulator_bypass,
  input wire logic        fraction_width_select,
  input wire logic        main_pump_polarity,
  input wire logic [21:0] fraction_numerator,
  input wire logic [21:0] fraction_denominator
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_pulse; main_power_up |=> !main_power_up; endproperty
  a_pulse: assert property (p_pulse) else $error("power up pulse too long");
  property p_both; aux_power_up |-> main_power_up; endproperty
  a_both: assert property (p_both) else $error("aux power up alone");
  property p_upcause; $rose(main_power_up) |-> $past(load_enable, 2); endproperty
  a_upcause: assert property (p_upcause) else $error("power up without load");
  property p_order; $changed(modulator_order) |-> $past(load_enable, 3); endproperty
  a_order: assert property (p_order) else $error("order changed without load");
  property p_width; $changed(fraction_width_select) |-> $past(load_enable, 3); endproperty
  a_width: assert property (p_width) else $error("width changed without load");
  property p_pol; $changed(main_pump_polarity) |-> $past(load_enable, 3); endproperty
  a_pol: assert property (p_pol) else $error("polarity changed without load");
  property p_byp; modulator_bypass == (modulator_order == 2'h1); endproperty
  a_byp: assert property (p_byp) else $error("bypass does not match order");
  property p_num;
    !fraction_width_select && !$past(fraction_width_select) |-> fraction_numerator[21:12] == 10'h0;
  endproperty
  a_num: assert property (p_num) else $error("numerator high bits used");
  property p_den;
    !fraction_width_select && !$past(fraction_width_select) |-> fraction_denominator[21:12] == 10'h0;
  endproperty
  a_den: assert property (p_den) else $error("denominator high bits used");
  c_aux: cover property (aux_power_up);
  c_wide: cover property (fraction_width_select);
  c_byp: cover property (modulator_bypass);
endmodule
bind scwd_decode scwd_checker scwd_checker_i (.clock, .rst, .load_enable, .main_power_up,
  .aux_power_up, .modulator_order, .modulator_bypass, .fraction_width_select,
  .main_pump_polarity, .fraction_numerator, .fraction_denominator);
`default_nettype wire

// >>> sim/scwd_host.sv
// host model shifting words into the decode block
`timescale 1ns/1ns
`default_nettype none
module scwd_host (
  input  wire logic clock,
  output logic      serial_clock,
  output logic      serial_data,
  output logic      load_enable
);
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    load_enable = 1'b0;
  end
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(negedge clock);
      serial_data = w[i];
      serial_clock = 1'b0;
      @(negedge clock);
      serial_clock = 1'b1;
      @(negedge clock);
    end
    @(negedge clock);
    serial_clock = 1'b0;
    serial_data = ~w[0];
    load_enable = 1'b1;
    repeat (3) @(negedge clock);
    load_enable = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the control word decode block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) chk(n, 24'(e), 24'(g))
module tb;
  logic        clock, rst, serial_clock, serial_data, load_enable, test_lock_pin_out;
  logic        test_lock_pin_oe_n, reference_differential, reference_doubler_enable;
  logic        main_power_up, aux_power_up, modulator_bypass, fraction_width_select;
  logic        aux_pump_polarity, aux_pump_hiz, main_pump_polarity, main_pump_hiz;
  logic [1:0]  modulator_order;
  logic [3:0]  lk, divider_outputs;
  logic [11:0] numerator_low_bits, denominator_low_bits;
  logic [21:0] fraction_numerator, fraction_denominator;
  logic        o, v, od;
  int          n_errors, checks_done, cyc, n_main, n_aux;
  scwd_decode scwd_decode_i (.clock, .rst, .serial_clock, .serial_data, .load_enable,
    .main_digital_lock(lk[0]), .aux_digital_lock(lk[1]), .main_analog_lock(lk[2]),
    .aux_analog_lock(lk[3]), .divider_outputs, .numerator_low_bits, .denominator_low_bits,
    .test_lock_pin_out, .test_lock_pin_oe_n, .reference_differential,
    .reference_doubler_enable, .main_power_up, .aux_power_up, .modulator_order,
    .modulator_bypass, .fraction_width_select, .aux_pump_polarity, .aux_pump_hiz,
    .main_pump_polarity, .main_pump_hiz, .fraction_numerator, .fraction_denominator);
  scwd_host host_i (.clock, .serial_clock, .serial_data, .load_enable);
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    checks_done++;
    if (e !== g) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [23:0] w);
    host_i.send(w);
    repeat (5) @(negedge clock);
  endtask
  function automatic logic [23:0] cw(logic [4:0] b, logic [1:0] o, a, d, logic [3:0] s);
    return {5'h00, b, o, a, d, s, 4'hB};
  endfunction
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(negedge clock) begin
    cyc++;
    if (main_power_up === 1'b1) n_main++;
    if (aux_power_up === 1'b1) n_aux++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    rst = 1'b1;
    lk = 4'h0;
    divider_outputs = 4'h0;
    numerator_low_bits = 12'hABC;
    denominator_low_bits = 12'h123;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    `CHK("oe_n reset", 1'b1, test_lock_pin_oe_n);
    for (int i = 0; i < 4; i++) begin
      wr(cw(5'h00, i[1:0], 2'h0, 2'h0, 4'h0));
      `CHK("order", i[1:0], modulator_order);
      `CHK("bypass", i == 1, modulator_bypass);
    end
    $display("test order done");
    for (int i = 0; i < 2; i++) begin
      wr(cw(i[0] ? 5'h15 : 5'h0A, 2'h0, 2'h0, {!i[0], i[0]}, 4'h0));
      `CHK("ref mode", i[0], reference_differential);
      `CHK("doubler", !i[0], reference_doubler_enable);
      `CHK("width", i[0], fraction_width_select);
      `CHK("aux pol", !i[0], aux_pump_polarity);
      `CHK("pump hiz", {2{i[0]}}, {aux_pump_hiz, main_pump_hiz});
      `CHK("main pol", !i[0], main_pump_polarity);
    end
    wr(24'hFFFFF9);
    `CHK("refused", 3'h4, {fraction_width_select, modulator_order});
    $display("test fields done");
    wr({10'h155, 10'h3FF, 4'hD});
    `CHK("num 22", {10'h3FF, 12'hABC}, fraction_numerator);
    `CHK("den 22", {10'h155, 12'h123}, fraction_denominator);
    wr(cw(5'h00, 2'h0, 2'h0, 2'h0, 4'h0));
    `CHK("num 12", {10'h0, 12'hABC}, fraction_numerator);
    `CHK("den 12", {10'h0, 12'h123}, fraction_denominator);
    $display("test fraction done");
    for (int a = 0; a < 4; a++) begin
      wr(cw(5'h14, 2'h0, a[1:0], 2'h0, 4'h0));
      n_main = 0;
      n_aux = 0;
      wr(24'h000010);
      `CHK("main up", a == 1 || a == 2, n_main);
      `CHK("aux up", a == 2, n_aux);
      `CHK("hiz", {a != 2, a == 0 || a == 3}, {aux_pump_hiz, main_pump_hiz});
    end
    $display("test power up done");
    for (int c = 0; c < 12; c++) begin
      wr(cw(5'h00, 2'h0, 2'h0, 2'h0, c[3:0]));
      for (int p = 0; p < 4; p++) begin
        lk = 4'(16'h5EB0 >> (4 * p));
        repeat (3) @(negedge clock);
        v = c == 1 ? 1'b1 : c == 3 ? lk[0] & lk[1] : c == 4 ? lk[0] : c == 5 ? lk[1] :
            c == 6 || c == 9 ? lk[2] & lk[3] : c == 7 || c == 10 ? lk[2] :
            c == 8 || c == 11 ? lk[3] : 1'b0;
        od = c >= 6 && c <= 8;
        `CHK("pin", {c == 0 || (od && v), v & ~od}, {test_lock_pin_oe_n, test_lock_pin_out & ~test_lock_pin_oe_n});
      end
    end
    for (int c = 12; c < 16; c++) begin
      wr(cw(5'h00, 2'h0, 2'h0, 2'h0, c[3:0]));
      o = test_lock_pin_out;
      for (int j = 1; j < 4; j++) begin
        divider_outputs = 4'hF;
        repeat (2) @(negedge clock);
        divider_outputs = 4'h0;
        repeat (2) @(negedge clock);
        divider_outputs = ~(4'h1 << (c - 12));
        repeat (2) @(negedge clock);
        divider_outputs = 4'h0;
        repeat (3) @(negedge clock);
        `CHK("divide", {1'b0, o ^ j[0]}, {test_lock_pin_oe_n, test_lock_pin_out});
      end
    end
    $display("test pin select done");
    final_report();
  end
endmodule
`default_nettype wire
